// [pkg/twss_pkg.sv]
/*
  Shared constants and types for the three-wire shift serial link: data width, edge counter
  layout, buffer depth, serial clock timing and the master sequencer states.
  Assumes it is compiled before the interface and both ends.
*/
package twss_pkg;

  // ********************************************************************
  // Data and counter layout
  // ********************************************************************
  localparam int          DATA_W      = 8;                 // Width of one transferred word.
  localparam int          CNT_W       = 4;                 // Width of the edge counter.
  localparam int          BIT_IDX_W   = 3;                 // Width of a bit index within a word.
  localparam int          FIFO_DEPTH  = 16;                // Received words the device buffers.
  localparam logic [3:0]  CNT_ZERO    = 4'h0;              // Edge counter value after a wrap.
  localparam logic [3:0]  CNT_FIRST   = 4'h1;              // Edge counter value after a frame's first edge.
  localparam logic [3:0]  CNT_STEP    = 4'h1;              // Edge counter increment.
  localparam logic [2:0]  LAST_BIT    = 3'h7;              // Index of the eighth bit of a word.
  localparam logic [7:0]  DATA_RESET  = 8'h00;             // Reset value of every data register.

  // ********************************************************************
  // Serial clock timing of the master end
  // ********************************************************************
  localparam int          CLK_PERIOD_NS   = 10;            // System clock period.
  localparam int          SCK_HALF_NS     = 80;            // Half period of the serial clock made by the master.
  localparam int          SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TMR_W           = 8;             // Width of the half period timer.
  localparam logic [7:0]  TMR_LOAD        = 8'(SCK_HALF_CYCLES - 1);
  localparam logic [7:0]  TMR_STEP        = 8'h01;

  // ********************************************************************
  // Master sequencer states, Gray coded along the bit loop
  // ********************************************************************
  typedef enum logic [1:0]
  {
    TWSS_IDLE   = 2'b00,                                   // Clock at rest, waiting for a start.
    TWSS_SETUP  = 2'b01,                                   // First bit shown, waiting before the first sample edge.
    TWSS_SAMPLE = 2'b11,                                   // Sample edge given, waiting for the change edge.
    TWSS_CHANGE = 2'b10                                    // Change edge given, waiting for the next sample edge.
  } twss_state_type;

endpackage : twss_pkg

// [pkg/twss_if.sv]
/*
  The three wires between the master end and the device end, with one modport for each.
  Assumes the bench instantiates it and joins the ends; the data output driver of the device
  is resolved here from its enable, and floats low when not driven.
*/
interface twss_if;

  logic sck;                                               // Serial clock line, made by the master.
  logic mosi;                                              // Master data output, device data input.
  logic miso_o;                                            // Device data output value.
  logic miso_oe;                                           // Device data output driver enable, high when driving.
  logic miso;                                              // Resolved level seen by the master.

  // Undriven line reads low; there is no pull on this wire.
  assign miso = miso_oe & miso_o;

  modport device
  (
    input  sck,
    input  mosi,
    output miso_o,
    output miso_oe
  );

  modport host
  (
    output sck,
    output mosi,
    input  miso
  );

endinterface : twss_if

// [verilog/twss_device.sv]
/*
  Device end of the three-wire shift serial link: the shift register and edge counter clocked
  by the serial clock line, an overflow flag and interrupt in the system clock domain, and a
  buffer of received words. Assumes the master keeps the serial clock still outside frames and
  that the transmit word and load are quasi-static for half a serial clock before a frame.
*/

// **********************************************************************
// Received word buffer
// **********************************************************************
// Plain synchronous buffer with valid and ready on both sides.
module twss_fifo
#(
  parameter int W     = 8,                                 // Word width.
  parameter int DEPTH = 16                                 // Word count.
)
(
  input  wire logic         CLOCK,                         // System clock.
  input  wire logic         RST_B,                         // Asynchronous reset, active low.
  input  wire logic [W-1:0] IN_DATA,                       // Word to store.
  input  wire logic         IN_VALID,                      // Word offered.
  output      logic         IN_READY,                      // Room for a word.
  output      logic [W-1:0] OUT_DATA,                      // Oldest word.
  output      logic         OUT_VALID,                     // A word is held.
  input  wire logic         OUT_READY                      // Oldest word taken.
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             fill;
  } twss_fifo_type;

  twss_fifo_type q;
  twss_fifo_type d;
  logic          push;
  logic          pop;

  // Full and empty follow the fill count, so both are exact.
  assign IN_READY  = (q.fill != (AW+1)'(DEPTH));
  assign OUT_VALID = (q.fill != '0);
  assign OUT_DATA  = q.mem[q.rd];
  assign push      = IN_VALID & IN_READY;
  assign pop       = OUT_VALID & OUT_READY;

  // Pointer and count update.
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = IN_DATA;
      d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
    end
    if (pop)
    begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
    end
    d.fill = q.fill + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      q <= '0;
    else
      q <= d;
  end
endmodule : twss_fifo

// **********************************************************************
// Device end
// **********************************************************************
module twss_device
(
  input  wire logic                  CLOCK,                // System clock.
  input  wire logic                  RST_B,                // Asynchronous reset, active low.
  twss_if.device                     LINK,                 // Serial wires.
  input  wire logic                  CLOCK_EDGE_SELECT,    // Edge mode, static during frames.
  input  wire logic                  OUT_ENABLE,           // Drive the data output.
  input  wire logic [twss_pkg::DATA_W-1:0] TX_DATA,        // Next word to send.
  input  wire logic                  TX_LOAD,              // Pulse: load word, restart counter.
  output      logic                  TX_LOAD_READY,        // Load accepted this cycle.
  input  wire logic                  OVF_CLEAR,            // Pulse: clear the overflow flag.
  input  wire logic                  IRQ_ENABLE,           // Overflow interrupt enable.
  output      logic                  OVF_FLAG,             // Sticky overflow flag.
  output      logic                  OVERRUN,              // Sticky: a word was lost.
  output      logic                  IRQ,                  // Interrupt and wake request.
  output      logic [twss_pkg::DATA_W-1:0] RX_DATA,        // Oldest received word.
  output      logic                  RX_VALID,             // Received word available.
  input  wire logic                  RX_READY              // Received word taken.
);
  import twss_pkg::*;

  typedef struct packed
  {
    logic [DATA_W-1:0] tx_word;
    logic              load_tgl;
    logic              done_s1;
    logic              done_s2;
    logic              done_seen;
    logic              pending;
    logic [DATA_W-1:0] rx_hold;
    logic              ovf;
    logic              overrun;
  } twss_sys_type;

  typedef struct packed
  {
    logic              din;
    logic [CNT_W-1:0]  rcnt;
  } twss_rise_type;

  typedef struct packed
  {
    logic [DATA_W-1:0] shreg;
    logic [CNT_W-1:0]  fcnt;
    logic              load_seen;
    logic              done_tgl;
    logic [DATA_W-1:0] rx_cap;
  } twss_fall_type;

  twss_sys_type  s_q;
  twss_sys_type  s_d;
  twss_rise_type r_q;
  twss_rise_type r_d;
  twss_fall_type f_q;
  twss_fall_type f_d;
  logic          sck_eff;
  logic          fresh;
  logic          done_evt;
  logic          fifo_ready;

  // ********************************************************************
  // Link side, clocked by the serial clock line
  // ********************************************************************
  // Inverting the line in mode 1 lets one pair of processes serve both modes; the select
  // must not change while the line is active or a false edge is seen.
  assign sck_eff = LINK.sck ^ CLOCK_EDGE_SELECT;

  // A load not yet seen by the link marks the next edge as the start of a frame. The load
  // toggle and word have been still for at least half a serial clock by then.
  assign fresh    = (s_q.load_tgl != f_q.load_seen);

  // The first bit is shown straight from the loaded word before any edge arrives.
  assign LINK.miso_o  = fresh ? s_q.tx_word[DATA_W-1] : f_q.shreg[DATA_W-1];
  assign LINK.miso_oe = OUT_ENABLE;

  // Sampling edge: latch the input bit and count the edge.
  always_comb
  begin
    r_d      = r_q;
    r_d.din  = LINK.mosi;
    r_d.rcnt = fresh ? CNT_FIRST : r_q.rcnt + CNT_STEP;
  end

  always_ff @(posedge sck_eff or negedge RST_B)
  begin
    if (!RST_B)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  // Change edge: shift the latched bit in, count the edge, report a wrap of the counter.
  always_comb
  begin
    logic [DATA_W-1:0] base;
    base          = fresh ? s_q.tx_word : f_q.shreg;
    f_d           = f_q;
    f_d.shreg     = {base[DATA_W-2:0], r_q.din};
    f_d.fcnt      = fresh ? CNT_FIRST : f_q.fcnt + CNT_STEP;
    f_d.load_seen = s_q.load_tgl;
    if (CNT_W'(r_q.rcnt + f_d.fcnt) == CNT_ZERO)
    begin
      f_d.done_tgl = ~f_q.done_tgl;
      f_d.rx_cap   = f_d.shreg;
    end
  end

  always_ff @(negedge sck_eff or negedge RST_B)
  begin
    if (!RST_B)
      f_q <= '0;
    else
      f_q <= f_d;
  end

  // ********************************************************************
  // System side
  // ********************************************************************
  // The done toggle passes two flops; its word was captured on the same edge that moved the toggle.
  assign done_evt      = (s_q.done_s2 != s_q.done_seen);
  assign TX_LOAD_READY = TX_LOAD & ~s_q.pending;
  assign OVF_FLAG      = s_q.ovf;
  assign OVERRUN       = s_q.overrun;
  assign IRQ           = s_q.ovf & IRQ_ENABLE;

  // A word waiting for buffer room blocks new loads, so the sender cannot overwrite it.
  always_comb
  begin
    s_d           = s_q;
    s_d.done_s1   = f_q.done_tgl;
    s_d.done_s2   = s_q.done_s1;
    s_d.done_seen = s_q.done_s2;
    if (s_q.pending && fifo_ready)
      s_d.pending = 1'b0;
    if (TX_LOAD_READY)
    begin
      s_d.tx_word  = TX_DATA;
      s_d.load_tgl = ~s_q.load_tgl;
    end
    if (OVF_CLEAR)
      s_d.ovf = 1'b0;
    if (done_evt)
    begin
      s_d.ovf = 1'b1;
      if (s_q.pending && !fifo_ready)
        s_d.overrun = 1'b1;
      else
      begin
        s_d.rx_hold = f_q.rx_cap;
        s_d.pending = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Received words wait here until the user takes them.
  twss_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .CLOCK     (CLOCK),
    .RST_B     (RST_B),
    .IN_DATA   (s_q.rx_hold),
    .IN_VALID  (s_q.pending),
    .IN_READY  (fifo_ready),
    .OUT_DATA  (RX_DATA),
    .OUT_VALID (RX_VALID),
    .OUT_READY (RX_READY)
  );
endmodule : twss_device

// [verilog/twss_host.sv]
/*
  Master end of the three-wire shift serial link: makes the serial clock from the system clock
  by a divider, shifts one word out and one word in per start. Assumes the device end follows
  the same edge mode and that the returned data line settles within a half period.
*/
module twss_host
(
  input  wire logic                  CLOCK,                // System clock.
  input  wire logic                  RST_B,                // Asynchronous reset, active low.
  twss_if.host                       LINK,                 // Serial wires.
  input  wire logic                  CLOCK_EDGE_SELECT,    // Edge mode, followed while idle, frozen at start.
  input  wire logic [twss_pkg::DATA_W-1:0] TX_DATA,        // Word to send.
  input  wire logic                  START,                // Pulse: begin a transfer.
  output      logic                  START_READY,          // Start accepted this cycle.
  output      logic                  BUSY,                 // Transfer in progress.
  output      logic                  DONE,                 // Pulse: word exchanged.
  output      logic [twss_pkg::DATA_W-1:0] RX_DATA         // Last word received.
);
  import twss_pkg::*;

  typedef struct packed
  {
    twss_state_type        state;
    logic [TMR_W-1:0]      tmr;
    logic [BIT_IDX_W-1:0]  bit_idx;
    logic [DATA_W-1:0]     sh;
    logic                  sck;
    logic                  mode;
    logic                  miso_s1;
    logic                  miso_s2;
    logic                  done;
    logic [DATA_W-1:0]     rx;
  } twss_host_type;

  twss_host_type q;
  twss_host_type d;
  logic          expired;

  assign expired     = (q.tmr == '0);
  assign START_READY = START & (q.state == TWSS_IDLE);
  assign BUSY        = (q.state != TWSS_IDLE);
  assign DONE        = q.done;
  assign RX_DATA     = q.rx;
  assign LINK.sck    = q.sck;
  assign LINK.mosi   = q.sh[DATA_W-1];

  // ********************************************************************
  // Bit sequencer
  // ********************************************************************
  // The clock rests at the mode level so the first edge of every pulse samples. Returned data
  // is read from its synchroniser at the end of the sampling half, just before the change edge.
  always_comb
  begin
    d         = q;
    d.miso_s1 = LINK.miso;
    d.miso_s2 = q.miso_s1;
    d.done    = 1'b0;
    d.tmr     = expired ? TMR_LOAD : q.tmr - TMR_STEP;
    case (q.state)
      TWSS_IDLE:
      begin
        // Following the select while idle puts the line at its rest level straight after reset,
        // so the first frame never opens with a stray change edge at the device.
        d.tmr  = TMR_LOAD;
        d.mode = CLOCK_EDGE_SELECT;
        d.sck  = CLOCK_EDGE_SELECT;
        if (START_READY)
        begin
          d.sh      = TX_DATA;
          d.bit_idx = '0;
          d.state   = TWSS_SETUP;
        end
      end
      TWSS_SETUP, TWSS_CHANGE:
      begin
        if (expired)
        begin
          d.sck   = ~q.sck;
          d.state = TWSS_SAMPLE;
        end
      end
      TWSS_SAMPLE:
      begin
        if (expired)
        begin
          d.sck     = ~q.sck;
          d.sh      = {q.sh[DATA_W-2:0], q.miso_s2};
          d.bit_idx = q.bit_idx + 3'h1;
          if (q.bit_idx == LAST_BIT)
          begin
            d.rx    = {q.sh[DATA_W-2:0], q.miso_s2};
            d.done  = 1'b1;
            d.state = TWSS_IDLE;
          end
          else
            d.state = TWSS_CHANGE;
        end
      end
      default:
      begin
        d.state = TWSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      q <= '0;
    else
      q <= d;
  end
endmodule : twss_host

// [verification/twss_props.sv]
/*
  Checker for the three serial wires between the master end and the device end.
  Assumes the bench instantiates it beside the link interface, in the system clock domain.
*/
module twss_props
(
  input wire logic CLOCK,             // System clock.
  input wire logic RST_B,             // Reset, active low.
  input wire logic CLOCK_EDGE_SELECT, // Edge mode.
  input wire logic sck,               // Serial clock line.
  input wire logic mosi,              // Master data line.
  input wire logic miso               // Resolved device data line.
);
  // ********************************************************************
  // Wire history
  // ********************************************************************
  typedef struct packed
  {
    logic       sck;
    logic       mosi;
    logic       miso;
    logic [3:0] quiet;
    logic [3:0] pulses;
    logic [3:0] mosi_age;
    logic [3:0] miso_age;
  } twss_watch_type;

  twss_watch_type w_q;
  twss_watch_type w_d;
  logic           samp;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  // A sample edge leaves the rest level; the rest level equals the mode.
  assign samp = (sck != w_q.sck) && (sck != CLOCK_EDGE_SELECT);

  // A gap of eight quiet cycles ends a frame, so the pulse count restarts there.
  always_comb
  begin
    w_d = w_q;
    w_d.sck = sck;
    w_d.mosi = mosi;
    w_d.miso = miso;
    if (sck != w_q.sck)
      w_d.quiet = 4'h0;
    else if (w_q.quiet != 4'hF)
      w_d.quiet = w_q.quiet + 4'h1;
    if (samp)
      w_d.pulses = (w_q.quiet >= 4'h8) ? 4'h1 : w_q.pulses + 4'h1;
    else if (w_q.quiet == 4'h8)
      w_d.pulses = 4'h0;
    if (mosi != w_q.mosi)
      w_d.mosi_age = 4'h0;
    else if (w_q.mosi_age != 4'hF)
      w_d.mosi_age = w_q.mosi_age + 4'h1;
    if (miso != w_q.miso)
      w_d.miso_age = 4'h0;
    else if (w_q.miso_age != 4'hF)
      w_d.miso_age = w_q.miso_age + 4'h1;
  end

  // History register.
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      w_q <= '0;
    else
      w_q <= w_d;
  end

  // ********************************************************************
  // Wire relations
  // ********************************************************************
  a_sck_pulse_pair : assert property (samp |=> $stable(sck)[*7] ##1 (sck != w_q.sck))
    else $error("change edge not eight cycles after sample edge");
  a_mosi_setup : assert property (samp |-> w_q.mosi_age >= 4'h7)
    else $error("master data not set up half a period before sampling");
  a_miso_setup : assert property (samp |-> w_q.miso_age >= 4'h7)
    else $error("device data not set up half a period before sampling");
  a_mosi_hold : assert property (samp |-> $stable(mosi)[*8])
    else $error("master data changed before the change edge");
  a_miso_hold : assert property (samp |-> $stable(miso)[*8])
    else $error("device data changed before the change edge");
  a_eight_pulses : assert property (w_q.quiet == 4'h8 |-> (w_q.pulses == 4'h0 || w_q.pulses == 4'h8))
    else $error("frame did not hold eight clock pulses");
  a_no_ninth : assert property (samp && w_q.quiet < 4'h8 |-> w_q.pulses < 4'h8)
    else $error("ninth pulse inside one frame");
  a_pulse_spacing : assert property (samp && (w_q.quiet >= 4'h8 || w_q.pulses < 4'h7) |-> ##16 samp)
    else $error("next sample edge not sixteen cycles later");

endmodule : twss_props

// [verification/twss_bench.sv]
/*
  Self-checking bench joining the master end and the device end over the link interface.
  Assumes the package, interface, both ends and the checker are compiled first.
*/
module twss_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import twss_pkg::*;

  logic              clock, rst_b, edge_sel, out_en, dev_load, ovf_clr, irq_en, dev_rx_ready, start;
  logic              dev_load_rdy, ovf_flag, overrun, irq, dev_rx_valid, start_rdy, busy, done;
  logic [DATA_W-1:0] dev_tx, dev_rx, host_tx, host_rx;
  int                errors, tests_run;

  twss_if link_if();
  twss_device u_twss_device (.CLOCK(clock), .RST_B(rst_b), .LINK(link_if), .CLOCK_EDGE_SELECT(edge_sel),
    .OUT_ENABLE(out_en), .TX_DATA(dev_tx), .TX_LOAD(dev_load), .TX_LOAD_READY(dev_load_rdy), .OVF_CLEAR(ovf_clr),
    .IRQ_ENABLE(irq_en), .OVF_FLAG(ovf_flag), .OVERRUN(overrun), .IRQ(irq), .RX_DATA(dev_rx),
    .RX_VALID(dev_rx_valid), .RX_READY(dev_rx_ready));
  twss_host u_twss_host (.CLOCK(clock), .RST_B(rst_b), .LINK(link_if), .CLOCK_EDGE_SELECT(edge_sel),
    .TX_DATA(host_tx), .START(start), .START_READY(start_rdy), .BUSY(busy), .DONE(done), .RX_DATA(host_rx));
  twss_props u_twss_props (.CLOCK(clock), .RST_B(rst_b), .CLOCK_EDGE_SELECT(edge_sel), .sck(link_if.sck),
    .mosi(link_if.mosi), .miso(link_if.miso));

  // System clock, 100 MHz.
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  // Inputs always move 1 ns after the rising edge, so no edge sees them half changed.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // The mode moves only inside reset, so the rest level shift never reaches a loaded frame.
  task automatic do_reset(input logic mode);
    rst_b = 1'b0;
    edge_sel = mode;
    tick(20);
    rst_b = 1'b1;
    tick(2);
  endtask : do_reset

  task automatic run_host(input logic [7:0] hw, input logic [7:0] exp_rx);
    int n;
    host_tx = hw;
    start = 1'b1;
    #1;
    chk("start_ready", start_rdy, 1'b1);
    tick(1);
    chk("busy", busy, 1'b1);
    chk("start_refused", start_rdy, 1'b0);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    // Done follows the accepting edge by sixteen half periods of the serial clock.
    chk("done_latency", n, 2 * DATA_W * SCK_HALF_CYCLES);
    chk("busy_end", busy, 1'b0);
    chk("host_rx", host_rx, exp_rx);
  endtask : run_host

  task automatic load_dev(input logic [7:0] dw, input logic exp_rdy);
    dev_tx = dw;
    dev_load = 1'b1;
    #1;
    chk("load_ready", dev_load_rdy, exp_rdy);
    tick(1);
    dev_load = 1'b0;
  endtask : load_dev

  task automatic pop(input logic [7:0] exp);
    chk("rx_valid", dev_rx_valid, 1'b1);
    chk("rx_data", dev_rx, exp);
    dev_rx_ready = 1'b1;
    tick(1);
    dev_rx_ready = 1'b0;
    tick(1);
  endtask : pop

  task automatic wait_flag();
    int n;
    n = 0;
    while (ovf_flag !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk("ovf_flag", ovf_flag, 1'b1);
    chk("irq", irq, irq_en);
    tick(12);
    chk("flag_sticky", ovf_flag, 1'b1);
  endtask : wait_flag

  task automatic clear_flag();
    ovf_clr = 1'b1;
    tick(1);
    ovf_clr = 1'b0;
    chk("flag_clear", ovf_flag, 1'b0);
    chk("irq_clear", irq, 1'b0);
  endtask : clear_flag

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic scen_single(input logic oe, input logic [7:0] hw, input logic [7:0] dw);
    out_en = oe;
    load_dev(dw, 1'b1);
    run_host(hw, oe ? dw : 8'h00);
    wait_flag();
    pop(hw);
    clear_flag();
  endtask : scen_single

  // Second start in the done cycle; the device sends back the word it just took in.
  task automatic scen_back_to_back();
    out_en = 1'b1;
    load_dev(8'h5A, 1'b1);
    run_host(8'hC3, 8'h5A);
    run_host(8'h96, 8'hC3);
    wait_flag();
    pop(8'hC3);
    pop(8'h96);
    clear_flag();
  endtask : scen_back_to_back

  // Sixteen words fill the buffer, one waits, the next is lost and a load is refused.
  task automatic scen_fifo_full();
    int i;
    for (i = 0; i < 17; i++)
      run_host(8'h10 + 8'(i), (i == 0) ? 8'h96 : 8'h0F + 8'(i));
    tick(12);
    load_dev(8'hEE, 1'b0);
    run_host(8'h40, 8'h20);
    tick(12);
    chk("overrun", overrun, 1'b1);
    for (i = 0; i < 17; i++)
      pop(8'h10 + 8'(i));
    chk("rx_empty", dev_rx_valid, 1'b0);
    clear_flag();
  endtask : scen_fifo_full

  // Main sequence.
  initial
  begin
    errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    edge_sel = 1'b0;
    out_en = 1'b1;
    dev_tx = 8'h00;
    dev_load = 1'b0;
    ovf_clr = 1'b0;
    irq_en = 1'b1;
    dev_rx_ready = 1'b0;
    host_tx = 8'h00;
    start = 1'b0;
    do_reset(1'b0);
    scen_single(1'b1, 8'hA5, 8'h3C);
    scen_back_to_back();
    scen_fifo_full();
    do_reset(1'b1);
    chk("overrun_reset", overrun, 1'b0);
    chk("rx_reset", host_rx, 8'h00);
    scen_single(1'b1, 8'h81, 8'h7E);
    irq_en = 1'b0;
    scen_single(1'b0, 8'h0F, 8'hFF);
    final_report();
  end

  // Watchdog: the run needs about 3150 cycles, so 20000 means a hang.
  initial
  begin
    #200000;
    errors++;
    final_report();
  end

endmodule : twss_bench
